// File: stack_exec_pkg.sv
// constants, types and layouts shared by the stack instruction execute logic
//
// Contract
// - push_literal_op stores its 8-bit literal at stack_frame_pointer, one word, one cycle
// - push_literal_op then decrements stack_frame_pointer by one
// - subtract_pointer_literal_op subtracts 6-bit k from indirect_pointer 0..2, flags kept
// - select 11 subtracts k from stack_frame_pointer, then returns to top_of_return_stack
// - subtract_unlink_return_op takes two cycles, second one a no-operation
// - enabling the extension also enables indexed literal offset addressing
// - extension off: file address is access bank, or bank_select_register bank
// - extension on, access bit 0, argument up to 5Fh: pointer plus offset
// - extension on, arguments above 5Fh keep literal addressing
// - pointer at 00h makes indexed accesses match ordinary access bank locations
// - indexed add_working_to_file_op adds W to pointer plus offset, sets five flags
// - destination bit 0 writes W, 1 writes the addressed byte
// - indexed bit_set_op sets bit b of pointer plus offset, flags kept, one cycle
// - indexed set_all_ones_op writes FFh to pointer plus offset, flags kept
// - extension_enable_bit resets to 0, extension disabled
package stack_exec_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam int NUM_PTR = 3;
  localparam int NIB_W = 4;
  localparam int FRAME_IDX = 2;

  // opcode fields
  localparam logic [7:0] OPC_PUSH = 8'hEA;
  localparam logic [7:0] OPC_SUBPTR = 8'hE9;
  localparam logic [5:0] OPC_ADD_WORK = 6'h09;
  localparam logic [3:0] OPC_BIT_SET = 4'h8;
  localparam logic [6:0] OPC_ALL_ONES = 7'h34;
  localparam logic [1:0] RET_SEL = 2'h3;

  // addressing
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;

  // register map of the plain register port
  localparam logic [REG_AW-1:0] REG_CONFIG = 4'h0;
  localparam logic [REG_AW-1:0] REG_PTR0 = 4'h1;
  localparam logic [REG_AW-1:0] REG_WORK = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h5;
  localparam logic [REG_AW-1:0] REG_BANK = 4'h6;
  localparam logic [REG_AW-1:0] REG_STATE = 4'h7;
  localparam logic EXT_RESET = 1'b0;

  typedef struct packed {logic [7:0] opc; logic [7:0] lit;} instr_lit_s;
  typedef struct packed {logic [7:0] opc; logic [1:0] sel; logic [5:0] k;} instr_sub_s;
  typedef struct packed {logic [5:0] opc; logic d; logic a; logic [7:0] f;} instr_byte_s;
  typedef struct packed {logic [3:0] opc; logic [2:0] b; logic a; logic [7:0] f;} instr_bit_s;
  typedef struct packed {logic [6:0] opc; logic a; logic [7:0] f;} instr_set_s;

  // flags as held in the status register, bit 4 down to bit 0
  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } flags_s;
  typedef struct packed {logic [ADDR_W-1:0] addr; logic we; logic [DATA_W-1:0] wdata;} mem_req_s;
  typedef struct packed {logic load; logic [PC_W-1:0] target;} ret_s;

  typedef enum logic [3:0] {Q1 = 4'h1, Q2 = 4'h2, Q3 = 4'h4, Q4 = 4'h8} q_e;
  typedef enum logic [1:0] {ST_RUN = 2'h1, ST_NOP = 2'h2} st_e;
  typedef enum logic [2:0] {OP_NONE, OP_PUSH, OP_SUBPTR, OP_SUBRET, OP_ADD, OP_BSET,
                            OP_ONES} op_e;
  typedef enum logic [1:0] {ALU_ADD, ALU_BSET, ALU_ONES} alu_e;
endpackage

// File: addr_resolve.sv
// file operand to data memory address mapping, literal or indexed
module addr_resolve import stack_exec_pkg::*; (
  input wire logic [7:0] f, // file argument from the opcode
  input wire logic a, // access bank select bit
  input wire logic ext, // extension enabled
  input wire logic [3:0] bank, // bank select register
  input wire logic [ADDR_W-1:0] frame, // stack frame pointer
  output logic [ADDR_W-1:0] addr // resolved data address
);
  // indexed substitution only for small access-bank arguments
  always_comb begin
    if (!a && ext && (f <= IDX_LIMIT)) begin
      // plain 12-bit add, wraps in the data space; frame 0 gives f itself
      addr = frame + {{(ADDR_W-8){1'b0}}, f};
    end else if (!a) begin
      addr = (f < ACCESS_SPLIT) ? {{(ADDR_W-8){1'b0}}, f} : {ACCESS_HI_BANK, f};
    end else begin
      addr = {bank, f};
    end
  end
endmodule

// File: byte_alu.sv
// byte operations for add, bit set and set-all-ones
module byte_alu import stack_exec_pkg::*; (
  input wire alu_e op, // operation select
  input wire logic [DATA_W-1:0] w, // working register
  input wire logic [DATA_W-1:0] m, // memory operand
  input wire logic [2:0] bitpos, // bit number for bit set
  output logic [DATA_W-1:0] res, // result byte
  output flags_s flg // flags, meaningful for add only
);
  logic [DATA_W:0] sum;
  logic [NIB_W:0] nib;

  // carries come from widened sums, overflow from sign agreement
  always_comb begin
    sum = {1'b0, w} + {1'b0, m};
    nib = {1'b0, w[NIB_W-1:0]} + {1'b0, m[NIB_W-1:0]};
    case (op)
      ALU_ADD: res = sum[DATA_W-1:0];
      ALU_BSET: res = m | (DATA_W'(1) << bitpos);
      ALU_ONES: res = ALL_ONES;
      default: res = m;
    endcase
    flg.c = sum[DATA_W];
    flg.digit_carry_flag = nib[NIB_W];
    flg.z = (sum[DATA_W-1:0] == '0);
    flg.n = sum[DATA_W-1];
    flg.overflow_flag = (w[DATA_W-1] == m[DATA_W-1]) && (sum[DATA_W-1] != w[DATA_W-1]);
  end
endmodule

// File: stack_exec.sv
// execute sequencer for the stack and indexed-offset instructions
//
// Added by the designer: the strobed register port and the address map.
module stack_exec import stack_exec_pkg::*; (
  input wire logic clk, // instruction clock, four per instruction cycle
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [REG_AW-1:0] reg_addr, // register port address
  input wire logic [REG_DW-1:0] reg_wdata, // register write data
  input wire logic reg_we, // register write strobe
  input wire logic reg_re, // register read strobe
  output logic [REG_DW-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic instr_valid, // fetched opcode present
  input wire logic [INSTR_W-1:0] instr, // fetched opcode
  output logic instr_ready, // opcode taken this cycle
  output mem_req_s mem_req, // data memory address, write strobe, data
  input wire logic [DATA_W-1:0] mem_rdata, // data memory read, same cycle
  input wire logic [PC_W-1:0] top_of_return_stack, // return stack top
  output ret_s ret // program counter load from return stack
);
  q_e q, next_q;
  st_e st, next_st;
  logic [INSTR_W-1:0] ir, next_ir;
  logic ir_ok, next_ir_ok;
  mem_req_s next_mem_req;
  ret_s next_ret;
  logic [DATA_W-1:0] res, next_res;
  flags_s flg, next_flg;
  logic [ADDR_W-1:0] ptr [NUM_PTR];
  logic [ADDR_W-1:0] next_ptr [NUM_PTR];
  logic [DATA_W-1:0] work, next_work;
  flags_s status, next_status;
  logic [3:0] bank, next_bank;
  logic ext, next_ext;
  logic [REG_DW-1:0] next_rdata;
  op_e op;
  alu_e alu_op;
  instr_lit_s i_lit;
  instr_sub_s i_sub;
  instr_byte_s i_byte;
  instr_bit_s i_bit;
  instr_set_s i_set;
  logic [ADDR_W-1:0] ea, wr_addr, k_ext;
  logic [DATA_W-1:0] alu_res;
  flags_s alu_flg;

  // opcode overlays
  assign i_lit = instr_lit_s'(ir);
  assign i_sub = instr_sub_s'(ir);
  assign i_byte = instr_byte_s'(ir);
  assign i_bit = instr_bit_s'(ir);
  assign i_set = instr_set_s'(ir);
  assign k_ext = {{(ADDR_W-6){1'b0}}, i_sub.k};

  // decode; anything unrecognised runs as a no-operation
  always_comb begin
    if (!ir_ok) begin
      op = OP_NONE;
    end else if (i_lit.opc == OPC_PUSH) begin
      op = OP_PUSH;
    end else if (i_sub.opc == OPC_SUBPTR) begin
      op = (i_sub.sel == RET_SEL) ? OP_SUBRET : OP_SUBPTR;
    end else if (i_byte.opc == OPC_ADD_WORK) begin
      op = OP_ADD;
    end else if (i_bit.opc == OPC_BIT_SET) begin
      op = OP_BSET;
    end else if (i_set.opc == OPC_ALL_ONES) begin
      op = OP_ONES;
    end else begin
      op = OP_NONE;
    end
    case (op)
      OP_ADD: alu_op = ALU_ADD;
      OP_BSET: alu_op = ALU_BSET;
      default: alu_op = ALU_ONES;
    endcase
  end

  // byte, bit and set formats share the a and f positions
  addr_resolve u_resolve (
    .f(i_byte.f),
    .a(i_byte.a),
    .ext(ext),
    .bank(bank),
    .frame(ptr[FRAME_IDX]),
    .addr(ea)
  );

  byte_alu u_alu (
    .op(alu_op),
    .w(work),
    .m(mem_rdata),
    .bitpos(i_bit.b),
    .res(alu_res),
    .flg(alu_flg)
  );

  assign wr_addr = (op == OP_PUSH) ? ptr[FRAME_IDX] : ea;
  assign instr_ready = (q == Q1) && (st == ST_RUN);

  // phase rotation, opcode capture and the return no-operation cycle
  always_comb begin
    next_ir = ir;
    next_ir_ok = ir_ok;
    next_st = st;
    case (q)
      Q1: next_q = Q2;
      Q2: next_q = Q3;
      Q3: next_q = Q4;
      Q4: next_q = Q1;
      default: next_q = Q1;
    endcase
    if (q == Q1) begin
      next_ir_ok = instr_ready && instr_valid;
      if (instr_ready && instr_valid) begin
        next_ir = instr;
      end
    end
    if (q == Q4) begin
      case (st)
        ST_RUN: next_st = (op == OP_SUBRET) ? ST_NOP : ST_RUN;
        ST_NOP: next_st = ST_RUN;
        default: next_st = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= Q1;
      st <= ST_RUN;
      ir <= '0;
      ir_ok <= 1'b0;
    end else if (ce) begin
      q <= next_q;
      st <= next_st;
      ir <= next_ir;
      ir_ok <= next_ir_ok;
    end
  end

  // address in Q2, read and compute in Q3, write strobe in Q4
  always_comb begin
    next_mem_req = mem_req;
    next_res = res;
    next_flg = flg;
    next_ret.load = 1'b0;
    next_ret.target = ret.target;
    case (q)
      Q2: begin
        next_mem_req.addr = wr_addr;
        next_mem_req.we = 1'b0;
      end
      Q3: begin
        next_res = alu_res;
        next_flg = alu_flg;
        next_mem_req.we = (op == OP_PUSH) || (op == OP_BSET) || (op == OP_ONES) ||
                          ((op == OP_ADD) && i_byte.d);
        next_mem_req.wdata = (op == OP_PUSH) ? i_lit.lit : alu_res;
      end
      Q4: begin
        next_mem_req.we = 1'b0;
        if (op == OP_SUBRET) begin
          next_ret.load = 1'b1;
          next_ret.target = top_of_return_stack;
        end
      end
      default: next_mem_req.we = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= '0;
      res <= '0;
      flg <= '0;
      ret <= '0;
    end else if (ce) begin
      mem_req <= next_mem_req;
      res <= next_res;
      flg <= next_flg;
      ret <= next_ret;
    end
  end

  // architectural state; the executing instruction wins over a port write in Q4
  always_comb begin
    next_work = work;
    next_status = status;
    next_bank = bank;
    next_ext = ext;
    for (int i = 0; i < NUM_PTR; i++) begin
      next_ptr[i] = ptr[i];
      if (reg_we && (reg_addr == REG_AW'(REG_PTR0 + REG_AW'(i)))) begin
        next_ptr[i] = reg_wdata[ADDR_W-1:0];
      end
      if ((q == Q4) && (op == OP_SUBPTR) && (i_sub.sel == 2'(i))) begin
        next_ptr[i] = ptr[i] - k_ext;
      end
      if ((q == Q4) && (i == FRAME_IDX)) begin
        if (op == OP_PUSH) begin
          next_ptr[i] = ptr[i] - PTR_STEP;
        end else if (op == OP_SUBRET) begin
          next_ptr[i] = ptr[i] - k_ext;
        end
      end
    end
    if (reg_we) begin
      case (reg_addr)
        REG_CONFIG: next_ext = reg_wdata[0];
        REG_WORK: next_work = reg_wdata[DATA_W-1:0];
        REG_STATUS: next_status = flags_s'(reg_wdata[$bits(flags_s)-1:0]);
        REG_BANK: next_bank = reg_wdata[3:0];
        default: next_ext = ext;
      endcase
    end
    if ((q == Q4) && (op == OP_ADD)) begin
      next_status = flg;
      if (!i_byte.d) begin
        next_work = res;
      end
    end
  end

  // reset leaves the extension off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr[i] <= '0;
      end
      work <= '0;
      status <= '0;
      bank <= '0;
      ext <= EXT_RESET;
    end else if (ce) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr[i] <= next_ptr[i];
      end
      work <= next_work;
      status <= next_status;
      bank <= next_bank;
      ext <= next_ext;
    end
  end

  // read mux; unmapped offsets read zero, data stands one cycle only
  always_comb begin
    next_rdata = '0;
    if (reg_re) begin
      case (reg_addr)
        REG_CONFIG: next_rdata = REG_DW'(ext);
        REG_PTR0: next_rdata = REG_DW'(ptr[0]);
        REG_PTR0 + 4'h1: next_rdata = REG_DW'(ptr[1]);
        REG_PTR0 + 4'h2: next_rdata = REG_DW'(ptr[2]);
        REG_WORK: next_rdata = REG_DW'(work);
        REG_STATUS: next_rdata = REG_DW'(status);
        REG_BANK: next_rdata = REG_DW'(bank);
        REG_STATE: next_rdata = REG_DW'({st, q});
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_push_store: assert property ((q == Q4) && (op == OP_PUSH) |->
    mem_req.we && (mem_req.wdata == i_lit.lit) && (mem_req.addr == ptr[FRAME_IDX]))
    else $error("push did not store literal at frame pointer");

  a_push_decr: assert property ((q == Q4) && ce && (op == OP_PUSH) |=>
    ptr[FRAME_IDX] == $past(ptr[FRAME_IDX]) - PTR_STEP)
    else $error("push did not decrement frame pointer");

  a_sub_pointer: assert property ((q == Q4) && ce && (op == OP_SUBPTR) && (i_sub.sel == 2'h1)
    |=> (ptr[1] == $past(ptr[1]) - $past(k_ext)) && $stable(status))
    else $error("pointer subtract wrong or flags changed");

  a_ret_load: assert property ((q == Q4) && ce && (op == OP_SUBRET) |=>
    ret.load && (ret.target == $past(top_of_return_stack)) &&
    (ptr[FRAME_IDX] == $past(ptr[FRAME_IDX]) - $past(k_ext)))
    else $error("subtract-return missed pointer or return load");

  a_ret_nop: assert property (ret.load |-> (st == ST_NOP) && !instr_ready
    && !mem_req.we ##1 !ret.load)
    else $error("return cycle not a two-cycle no-operation");

  a_index_addr: assert property ((q == Q3) && (op == OP_ADD) && ext && !i_byte.a &&
    (i_byte.f <= IDX_LIMIT) |->
    mem_req.addr == ptr[FRAME_IDX] + {{(ADDR_W-8){1'b0}}, i_byte.f})
    else $error("indexed address not pointer plus offset");

  a_literal_addr: assert property ((q == Q3) && (op == OP_ONES) && !i_set.a &&
    (!ext || (i_set.f > IDX_LIMIT)) && (i_set.f < ACCESS_SPLIT) |->
    mem_req.addr == {{(ADDR_W-8){1'b0}}, i_set.f})
    else $error("literal access bank address wrong");

  a_add_dest: assert property ((q == Q4) && ce && (op == OP_ADD) |->
    (mem_req.we == i_byte.d) ##1 (status == $past(flg)) &&
    (work == ($past(i_byte.d) ? $past(work) : $past(res))))
    else $error("add result or flags to wrong place");

  a_bit_set: assert property ((q == Q4) && (op == OP_BSET) |->
    mem_req.we && mem_req.wdata[i_bit.b] && ((mem_req.wdata & ~(DATA_W'(1) << i_bit.b))
    == ($past(mem_rdata) & ~(DATA_W'(1) << i_bit.b))))
    else $error("bit set wrote wrong byte");

  a_set_ones: assert property ((q == Q4) && ce && (op == OP_ONES) |->
    mem_req.we && (mem_req.wdata == ALL_ONES) ##1 $stable(status))
    else $error("set-all-ones wrong or flags changed");

  a_ext_write: assert property ($rose(ext) |-> $past(reg_we && (reg_addr == REG_CONFIG)))
    else $error("extension enabled without config write");
endmodule

// File: stack_exec_tb.sv
// self-checking bench for the stack and indexed-offset execute sequencer
module stack_exec_tb import stack_exec_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [REG_AW-1:0] P2 = REG_PTR0 + 4'h2;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr = '0;
  logic instr_ready;
  mem_req_s mem_req;
  logic [DATA_W-1:0] mem_rdata;
  logic [PC_W-1:0] top_of_return_stack = 21'h1ABCD;
  ret_s ret;
  logic [7:0] mem [0:4095];
  logic [11:0] waddr;
  logic [7:0] wdata;
  logic [PC_W-1:0] rtgt;
  int wcnt = 0;
  int rcnt = 0;
  int cyc = 0;
  int err_total = 0;
  int checks = 0;

  always #20 clk = ~clk;

  stack_exec dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .mem_req(mem_req), .mem_rdata(mem_rdata),
    .top_of_return_stack(top_of_return_stack), .ret(ret));

  // memory answers in the same clock, so the read sampled at end of Q3 is ready
  assign mem_rdata = mem[mem_req.addr];

  // record writes and returns; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_req.we === 1'b1) begin
      mem[mem_req.addr] <= mem_req.wdata;
      wcnt <= wcnt + 1;
      waddr <= mem_req.addr;
      wdata <= mem_req.wdata;
    end
    if (ret.load === 1'b1) begin
      rcnt <= rcnt + 1;
      rtgt <= ret.target;
    end
    if (cyc == LIMIT) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk("reg_rdata", {16'h0, exp}, {16'h0, reg_rdata});
    @(posedge clk);
    #1;
    chk("reg_rdata idle", 32'h0, {16'h0, reg_rdata});
  endtask

  // offer an opcode, hold it until taken in Q1, return after the Q4 update edge
  task automatic exec(input logic [INSTR_W-1:0] op);
    int n;
    @(posedge clk);
    wcnt = 0;
    instr_valid <= 1'b1;
    instr <= op;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 12);
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic xw(input logic [11:0] a, input logic [7:0] d);
    chk("write count", 32'h1, wcnt);
    chk("write addr", {20'h0, a}, {20'h0, waddr});
    chk("write data", {24'h0, d}, {24'h0, wdata});
  endtask

  task automatic ones_at(input logic a, input logic [7:0] f, input logic [11:0] ea);
    exec({OPC_ALL_ONES, a, f});
    xw(ea, ALL_ONES);
  endtask

  task automatic t_reset;
    rd(REG_CONFIG, 16'h0000);
    rd(P2, 16'h0000);
    wr(4'hE, 16'hFFFF);
    rd(4'hE, 16'h0000);
    wr(REG_STATUS, 16'h001F);
    rd(REG_STATUS, 16'h001F);
  endtask

  task automatic t_push;
    wr(P2, 16'h01EC);
    exec({OPC_PUSH, 8'h08});
    xw(12'h1EC, 8'h08);
    rd(P2, 16'h01EB);
    exec({OPC_PUSH, 8'hFF});
    xw(12'h1EB, 8'hFF);
    rd(P2, 16'h01EA);
  endtask

  // largest literal against each of the three pointers, flags untouched
  task automatic t_subptr;
    for (int i = 0; i < 3; i++) begin
      wr(REG_PTR0 + 4'(i), 16'h03FF);
      wr(REG_STATUS, 16'h0015);
      exec({OPC_SUBPTR, 2'(i), 6'h3F});
      chk("sub writes", 32'h0, wcnt);
      rd(REG_PTR0 + 4'(i), 16'h03C0);
      rd(REG_STATUS, 16'h0015);
    end
  endtask

  task automatic t_subret;
    int n;
    wr(P2, 16'h03FF);
    wr(REG_PTR0, 16'h0123);
    rcnt = 0;
    exec({OPC_SUBPTR, RET_SEL, 6'h23});
    chk("sub-return writes", 32'h0, wcnt);
    // Q1 of the no-op cycle passed inside exec; Q2 to Q4 remain
    n = 0;
    repeat (3) begin
      @(negedge clk);
      if (instr_ready !== 1'b0) n++;
    end
    chk("ready in no-op cycle", 32'h0, n);
    @(negedge clk);
    chk("ready after no-op", 32'h1, {31'h0, instr_ready});
    chk("return loads", 32'h1, rcnt);
    chk("return target", {11'h0, 21'h1ABCD}, {11'h0, rtgt});
    rd(P2, 16'h03DC);
    rd(REG_PTR0, 16'h0123);
    // strobe lands in Q4 of a run cycle here, so state reads run and Q4
    rd(REG_STATE, 16'h0018);
  endtask

  // carry, zero and overflow from 80h+80h; negative, overflow, digit carry from 0Fh+71h
  task automatic t_add;
    wr(REG_CONFIG, 16'h0001);
    wr(P2, 16'h0A00);
    mem[12'hA2C] = 8'h80;
    wr(REG_WORK, 16'h0080);
    wr(REG_STATUS, 16'h0000);
    exec({OPC_ADD_WORK, 1'b0, 1'b0, 8'h2C});
    chk("add d0 writes", 32'h0, wcnt);
    rd(REG_WORK, 16'h0000);
    rd(REG_STATUS, 16'h000D);
    mem[12'hA2C] = 8'h71;
    wr(REG_WORK, 16'h000F);
    exec({OPC_ADD_WORK, 1'b1, 1'b0, 8'h2C});
    xw(12'hA2C, 8'h80);
    rd(REG_WORK, 16'h000F);
    rd(REG_STATUS, 16'h001A);
  endtask

  task automatic t_bset;
    wr(REG_STATUS, 16'h001F);
    mem[12'hA0A] = 8'h55;
    exec({OPC_BIT_SET, 3'd7, 1'b0, 8'h0A});
    xw(12'hA0A, 8'hD5);
    for (int b = 0; b < 7; b++) begin
      mem[12'hA0A] = 8'h00;
      exec({OPC_BIT_SET, 3'(b), 1'b0, 8'h0A});
      xw(12'hA0A, 8'h01 << b);
    end
    rd(REG_STATUS, 16'h001F);
  endtask

  // clock enable low: port writes ignored, state held until it returns
  task automatic t_freeze;
    wr(REG_WORK, 16'h0033);
    @(posedge clk);
    ce <= 1'b0;
    wr(REG_WORK, 16'h00CC);
    wr(P2, 16'h0123);
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    rd(REG_WORK, 16'h0033);
    rd(P2, 16'h0A00);
  endtask

  task automatic t_literal;
    wr(REG_CONFIG, 16'h0000);
    wr(REG_BANK, 16'h0005);
    wr(P2, 16'h0A00);
    ones_at(1'b0, 8'h2C, 12'h02C);
    ones_at(1'b0, 8'h90, 12'hF90);
    ones_at(1'b1, 8'h2C, 12'h52C);
  endtask

  // offset boundary, bank access kept, wrap at 4 KB, pointer zero
  task automatic t_indexed;
    wr(REG_CONFIG, 16'h0001);
    ones_at(1'b0, 8'h2C, 12'hA2C);
    ones_at(1'b0, 8'h5F, 12'hA5F);
    ones_at(1'b0, 8'h60, 12'h060);
    ones_at(1'b1, 8'h2C, 12'h52C);
    wr(P2, 16'h0FF0);
    ones_at(1'b0, 8'h20, 12'h010);
    wr(P2, 16'h0000);
    ones_at(1'b0, 8'h2C, 12'h02C);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // reset held for 20 clocks, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    $display("test reset done");
    t_push();
    $display("test push done");
    t_subptr();
    $display("test subtract pointer done");
    t_subret();
    $display("test subtract return done");
    t_literal();
    $display("test literal addressing done");
    t_indexed();
    $display("test indexed addressing done");
    t_add();
    $display("test indexed add done");
    t_bset();
    $display("test indexed bit set done");
    t_freeze();
    $display("test clock enable done");
    stop_test();
  end
endmodule
